// [fsec_controller.sv]
// Flash access controller: line ECC, sector decode, boot block guard and remap
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RQ1] One ECC byte protects each aligned 128-bit flash line.
// [RQ2] ECC byte index is byte address divided by sixteen.
// [RQ3] Hamming code corrects any single-bit error in a line; in the code an erased line (ECC 0xFF) holds no valid ECC and is not corrected.
// [RQ4] Every read fetches the whole line plus its ECC byte.
// [RQ5] A single-bit error is corrected before data returns to the CPU.
// [RQ6] Every line program stores the ECC computed from the written data.
// [RQ7] ECC storage is never readable or writable by user code.
// [RQ8] Erasing a sector also erases all its ECC bytes.
// [RQ9] A written ECC byte is not rewritten until its sector is erased.
// [RQ10] Software programs only whole aligned 16-byte groups.
// [RQ11] No flash reads are served during erase or program.
// [RQ12] Sectors 0 to 7 are 8 kB from zero in every size.
// [RQ13] 128 kB array: sectors 0 to 15 are 8 kB each.
// [RQ14] 256 kB array: sectors 8 and 9 are 64 kB at 0x10000, 0x20000.
// [RQ15] 256 kB array: sectors 10 to 17 are 8 kB from 0x30000.
// [RQ16] Top 8 kB is the boot block, not available to user code.
// [RQ17] Program, erase and go aimed at the boot block are rejected.
// [RQ18] Software masks interrupts or runs vectors from RAM while flash is busy.
// [RQ19] After reset the boot block vectors are the active ones.
// [RQ20] After reset the boot block is also visible from 0x7FFFE000.
// [RQ21] After reset boot block's low 64 bytes overlay address zero until disabled.
// [RQ22] An uncorrectable line is returned raw without stalling.
// [RQ23] An erased line with erased ECC reads back uncorrected.
module fsec_controller (
   input  wire logic                       clk,
   input  wire logic                       reset,
   input  wire logic                       clkEn,
   input  wire fsec_pkg::fsec_size_t       sizeSel,
   input  wire logic                       overlayOff,
   input  wire logic                       rdReq,
   input  wire logic [31:0]                rdAddr,
   output logic                            rdReady,
   output logic                            rdValid,
   output logic [fsec_pkg::WORD_W-1:0]     rdData,
   output logic                            eccFixed,
   output logic                            eccUncorr,
   input  wire logic                       cmdValid,
   input  wire fsec_pkg::fsec_cmd_t        cmd,
   output logic                            cmdReady,
   output logic                            cmdDone,
   output fsec_pkg::fsec_status_t          cmdStatus,
   output fsec_pkg::fsec_arr_t             arrReq,
   input  wire logic [fsec_pkg::LINE_W-1:0] arrRdData,
   input  wire logic [fsec_pkg::ECC_W-1:0]  arrRdEcc,
   input  wire logic                       arrDone
);

   // ----------------------------------------------------------------------
   // Hamming code over one line
   // ----------------------------------------------------------------------
   // Data bit i sits at the i-th non power of two position; 8 check bits reach 255
   function automatic logic [fsec_pkg::ECC_W-1:0] hamEnc(input logic [fsec_pkg::LINE_W-1:0] d);
      logic [fsec_pkg::ECC_W-1:0] c;
      int                         p;
      c = '0;
      p = 2;
      for (int i = 0; i < fsec_pkg::LINE_W; i++) begin
         p = p + 1;
         if ((p & (p - 1)) == 0) begin
            p = p + 1;
         end
         if (d[i]) begin
            c = c ^ p[7:0]; // [RQ3]
         end
      end
      return c;
   endfunction

   function automatic fsec_pkg::fsec_dec_t hamDec(input logic [fsec_pkg::LINE_W-1:0] d,
                                                  input logic [fsec_pkg::ECC_W-1:0] e);
      fsec_pkg::fsec_dec_t        r;
      logic [fsec_pkg::ECC_W-1:0] s;
      logic                       hit;
      int                         p;
      r.data   = d;
      r.fixed  = 1'b0;
      r.uncorr = 1'b0;
      hit      = 1'b0;
      p        = 2;
      s        = e ^ hamEnc(d);
      if (d == '1 && e == fsec_pkg::ECC_ERASED) begin
         return r; // [RQ23]
      end
      for (int i = 0; i < fsec_pkg::LINE_W; i++) begin
         p = p + 1;
         if ((p & (p - 1)) == 0) begin
            p = p + 1;
         end
         if (s != '0 && p[7:0] == s) begin
            r.data[i] = ~d[i]; // [RQ5]
            hit       = 1'b1;
         end
      end
      if (s != '0) begin
         // Syndrome beyond the last data position cannot be mapped: leave raw
         if (hit || (s & (s - 8'h01)) == '0) begin
            r.fixed = 1'b1;
         end else begin
            r.uncorr = 1'b1; // [RQ22]
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Array geometry
   // ----------------------------------------------------------------------
   logic [31:0]                 flashTop;
   logic [31:0]                 bootBase;
   logic [31:0]                 sectBase;
   logic [31:0]                 sectLen;
   logic                        sectOk;
   logic [fsec_pkg::SECT_W-1:0] sectNum;

   assign sectNum = cmd.addr[fsec_pkg::SECT_W-1:0];

   always_comb begin
      case (sizeSel)
         fsec_pkg::SZ_64K:  flashTop = fsec_pkg::FLASH_64K;
         fsec_pkg::SZ_128K: flashTop = fsec_pkg::FLASH_128K;
         default:           flashTop = fsec_pkg::FLASH_256K;
      endcase
   end

   assign bootBase = flashTop - fsec_pkg::BOOT_SIZE; // [RQ16]

   always_comb begin
      sectBase = 32'(sectNum) * fsec_pkg::SECT_SMALL; // [RQ12] [RQ13]
      sectLen  = fsec_pkg::SECT_SMALL;
      sectOk   = cmd.addr[31:fsec_pkg::SECT_W] == '0;
      case (sizeSel)
         fsec_pkg::SZ_64K:  sectOk = sectOk && sectNum <= fsec_pkg::LAST_SECT_64K;
         fsec_pkg::SZ_128K: sectOk = sectOk && sectNum <= fsec_pkg::LAST_SECT_128K;
         default: begin
            sectOk = sectOk && sectNum <= fsec_pkg::LAST_SECT_256K;
            if (sectNum >= fsec_pkg::FIRST_HI_SECT) begin
               sectBase = fsec_pkg::HI_SMALL_BASE
                          + 32'(sectNum - fsec_pkg::FIRST_HI_SECT) * fsec_pkg::SECT_SMALL; // [RQ15]
            end else if (sectNum >= fsec_pkg::FIRST_BIG_SECT) begin
               sectBase = fsec_pkg::BIG_BASE
                          + 32'(sectNum - fsec_pkg::FIRST_BIG_SECT) * fsec_pkg::SECT_BIG; // [RQ14]
               sectLen  = fsec_pkg::SECT_BIG;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Request acceptance and checks
   // ----------------------------------------------------------------------
   fsec_pkg::fsec_state_t  stateQ;
   logic                   overlayQ;
   logic [31:0]            rdMapped;
   logic                   rdTake;
   logic                   cmdTake;
   logic                   cmdInBoot;
   logic                   cmdBadAddr;
   fsec_pkg::fsec_status_t cmdVerdict;

   assign rdReady = stateQ == fsec_pkg::S_IDLE; // [RQ11]
   assign cmdReady = stateQ == fsec_pkg::S_IDLE && !rdReq;
   assign rdTake = rdReq && rdReady && clkEn;
   assign cmdTake = cmdValid && cmdReady && clkEn;

   // Aliases land in the real boot block, so ECC covers them as well
   always_comb begin
      rdMapped = rdAddr;
      if (rdAddr >= fsec_pkg::BOOT_ALIAS) begin
         rdMapped = bootBase + (rdAddr - fsec_pkg::BOOT_ALIAS); // [RQ20]
      end else if (overlayQ && rdAddr < fsec_pkg::VEC_SIZE) begin
         rdMapped = bootBase + rdAddr; // [RQ19] [RQ21]
      end
   end

   always_comb begin
      if (cmd.op == fsec_pkg::OP_ERASE) begin
         cmdBadAddr = !sectOk;
         cmdInBoot  = sectBase >= bootBase;
      end else begin
         cmdBadAddr = cmd.addr >= flashTop;
         cmdInBoot  = cmd.addr >= bootBase;
      end
      if (cmdBadAddr) begin
         cmdVerdict = fsec_pkg::ST_BAD_ADDR;
      end else if (cmdInBoot) begin
         cmdVerdict = fsec_pkg::ST_BOOT; // [RQ17]
      end else begin
         cmdVerdict = fsec_pkg::ST_OK;
      end
   end

   // ----------------------------------------------------------------------
   // Overlay of the boot vectors
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         overlayQ <= 1'b1; // [RQ21]
      end else if (clkEn && overlayOff) begin
         overlayQ <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   logic                       isProgQ;
   logic [fsec_pkg::WSEL_W-1:0] wordSelQ;
   fsec_pkg::fsec_dec_t        dec;
   logic                       eccUsed;

   assign dec = hamDec(arrRdData, arrRdEcc); // [RQ4]
   assign eccUsed = arrRdEcc != fsec_pkg::ECC_ERASED;

   always_ff @(posedge clk) begin
      if (reset) begin
         stateQ    <= fsec_pkg::S_IDLE;
         isProgQ   <= 1'b0;
         wordSelQ  <= '0;
         arrReq    <= '0;
         cmdDone   <= 1'b0;
         cmdStatus <= fsec_pkg::ST_OK;
      end else if (clkEn) begin
         arrReq.rdEn <= 1'b0;
         arrReq.wrEn <= 1'b0;
         arrReq.erEn <= 1'b0;
         cmdDone     <= 1'b0;
         case (stateQ)
            fsec_pkg::S_IDLE: begin
               if (rdTake) begin
                  arrReq.rdEn <= 1'b1;
                  arrReq.line <= rdMapped[fsec_pkg::ADDR_W-1:fsec_pkg::LINE_SHIFT]; // [RQ1] [RQ2]
                  wordSelQ    <= rdMapped[fsec_pkg::LINE_SHIFT-1:fsec_pkg::WSEL_W];
                  isProgQ     <= 1'b0;
                  stateQ      <= fsec_pkg::S_FETCH;
               end else if (cmdTake && cmdVerdict != fsec_pkg::ST_OK) begin
                  cmdDone   <= 1'b1;
                  cmdStatus <= cmdVerdict; // [RQ17]
               end else if (cmdTake && cmd.op == fsec_pkg::OP_PROG) begin
                  // Read the line first so a used ECC byte is never overwritten
                  arrReq.rdEn   <= 1'b1;
                  arrReq.line   <= cmd.addr[fsec_pkg::ADDR_W-1:fsec_pkg::LINE_SHIFT]; // [RQ10]
                  arrReq.wrData <= cmd.data;
                  arrReq.wrEcc  <= hamEnc(cmd.data); // [RQ6]
                  isProgQ       <= 1'b1;
                  stateQ        <= fsec_pkg::S_FETCH;
               end else if (cmdTake && cmd.op == fsec_pkg::OP_ERASE) begin
                  arrReq.erEn       <= 1'b1; // [RQ8]
                  arrReq.line       <= sectBase[fsec_pkg::ADDR_W-1:fsec_pkg::LINE_SHIFT];
                  arrReq.eraseLines <= sectLen[fsec_pkg::ADDR_W:fsec_pkg::LINE_SHIFT];
                  stateQ            <= fsec_pkg::S_ERASE;
               end else if (cmdTake) begin
                  cmdDone   <= 1'b1;
                  cmdStatus <= fsec_pkg::ST_OK;
               end
            end
            fsec_pkg::S_FETCH: begin
               stateQ <= fsec_pkg::S_CAPTURE;
            end
            fsec_pkg::S_CAPTURE: begin
               if (!isProgQ) begin
                  stateQ <= fsec_pkg::S_IDLE;
               end else if (eccUsed) begin
                  cmdDone   <= 1'b1;
                  cmdStatus <= fsec_pkg::ST_ECC_USED; // [RQ9]
                  stateQ    <= fsec_pkg::S_IDLE;
               end else begin
                  arrReq.wrEn <= 1'b1;
                  stateQ      <= fsec_pkg::S_PROG;
               end
            end
            fsec_pkg::S_PROG, fsec_pkg::S_ERASE: begin
               if (arrDone) begin
                  cmdDone   <= 1'b1;
                  cmdStatus <= fsec_pkg::ST_OK;
                  stateQ    <= fsec_pkg::S_IDLE;
               end
            end
            default: begin
               stateQ <= fsec_pkg::S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Read answer; only the selected word of the corrected line leaves here
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         rdValid   <= 1'b0;
         rdData    <= '0;
         eccFixed  <= 1'b0;
         eccUncorr <= 1'b0;
      end else if (clkEn) begin
         rdValid <= stateQ == fsec_pkg::S_CAPTURE && !isProgQ;
         if (stateQ == fsec_pkg::S_CAPTURE && !isProgQ) begin
            rdData    <= dec.data[wordSelQ * fsec_pkg::WORD_W +: fsec_pkg::WORD_W]; // [RQ5] [RQ7]
            eccFixed  <= dec.fixed;
            eccUncorr <= dec.uncorr; // [RQ22]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks (valid while clkEn stays high)
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset || !clkEn);

   sequence rdIssue;
      rdTake ##1 arrReq.rdEn;
   endsequence

   a_read_latency: assert property (rdTake |-> rdIssue ##2 rdValid) // [RQ4]
      else $error("read answer not three cycles after acceptance");
   a_busy_stall: assert property ((arrReq.wrEn || arrReq.erEn) |-> !rdReady) // [RQ11]
      else $error("read accepted while flash busy");
   a_boot_reject: assert property (cmdTake && cmdInBoot && !cmdBadAddr
                                   |=> cmdDone && cmdStatus == fsec_pkg::ST_BOOT && !arrReq.erEn) // [RQ17]
      else $error("boot block command not rejected");
   a_prog_guard: assert property (arrReq.wrEn
                                  |-> {arrReq.line, 4'h0} < bootBase[fsec_pkg::ADDR_W-1:0]) // [RQ16]
      else $error("program reached the boot block");
   a_ecc_once: assert property (stateQ == fsec_pkg::S_CAPTURE && isProgQ && eccUsed
                                |=> cmdDone && cmdStatus == fsec_pkg::ST_ECC_USED && !arrReq.wrEn) // [RQ9]
      else $error("used ECC byte rewritten");
   a_ecc_stored: assert property (arrReq.wrEn |-> arrReq.wrEcc == hamEnc(arrReq.wrData)) // [RQ6]
      else $error("stored ECC does not match data");
   a_erased_clean: assert property (stateQ == fsec_pkg::S_CAPTURE && !isProgQ && arrRdData == '1
                                    && !eccUsed |=> rdValid && !eccFixed && !eccUncorr) // [RQ23]
      else $error("erased line was corrected");
   a_boot_alias: assert property (rdTake && rdAddr >= fsec_pkg::BOOT_ALIAS
                                  |=> arrReq.rdEn && arrReq.line[fsec_pkg::LINE_AW-1:9]
                                      == bootBase[fsec_pkg::ADDR_W-1:13]) // [RQ20]
      else $error("alias read missed the boot block");
   a_erase_sector: assert property (cmdTake && cmd.op == fsec_pkg::OP_ERASE && cmdVerdict == fsec_pkg::ST_OK
                                    |=> arrReq.erEn ##1 !rdReady) // [RQ8]
      else $error("erase not issued or reads not stalled");

endmodule
`default_nettype wire

// [fsec_pkg.sv]
// Shared constants, enumerations and carriers of the flash sector ECC controller
package fsec_pkg;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int          ADDR_W     = 18;                // Byte address bits of the largest array
   localparam int          LINE_SHIFT = 4;                 // 16 bytes per protected line
   localparam int          LINE_AW    = ADDR_W - LINE_SHIFT;
   localparam int          LINE_W     = 128;
   localparam int          ECC_W      = 8;
   localparam int          WORD_W     = 32;
   localparam int          WSEL_W     = 2;
   localparam int          SECT_W     = 5;
   localparam logic [7:0]  ECC_ERASED = 8'hFF;

   localparam logic [31:0] FLASH_64K     = 32'h0001_0000;
   localparam logic [31:0] FLASH_128K    = 32'h0002_0000;
   localparam logic [31:0] FLASH_256K    = 32'h0004_0000;
   localparam logic [31:0] SECT_SMALL    = 32'h0000_2000;
   localparam logic [31:0] SECT_BIG      = 32'h0001_0000;
   localparam logic [31:0] BIG_BASE      = 32'h0001_0000;
   localparam logic [31:0] HI_SMALL_BASE = 32'h0003_0000;
   localparam logic [31:0] BOOT_SIZE     = 32'h0000_2000;
   localparam logic [31:0] BOOT_ALIAS    = 32'h7FFF_E000;
   localparam logic [31:0] VEC_SIZE      = 32'h0000_0040;

   localparam logic [SECT_W-1:0] LAST_SECT_64K  = 5'h07;
   localparam logic [SECT_W-1:0] LAST_SECT_128K = 5'h0F;
   localparam logic [SECT_W-1:0] LAST_SECT_256K = 5'h11;
   localparam logic [SECT_W-1:0] LAST_LOW_SECT  = 5'h07;
   localparam logic [SECT_W-1:0] FIRST_BIG_SECT = 5'h08;
   localparam logic [SECT_W-1:0] FIRST_HI_SECT  = 5'h0A;

   // ----------------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {SZ_64K = 2'b00, SZ_128K = 2'b01, SZ_256K = 2'b10} fsec_size_t;
   typedef enum logic [1:0] {OP_PROG = 2'b00, OP_ERASE = 2'b01, OP_GO = 2'b10} fsec_op_t;
   typedef enum logic [2:0] {
      ST_OK       = 3'b000,
      ST_BOOT     = 3'b001,
      ST_BAD_ADDR = 3'b010,
      ST_ECC_USED = 3'b011
   } fsec_status_t;
   typedef enum logic [2:0] {
      S_IDLE    = 3'b000,
      S_FETCH   = 3'b001,
      S_CAPTURE = 3'b010,
      S_PROG    = 3'b011,
      S_ERASE   = 3'b100
   } fsec_state_t;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      fsec_op_t          op;
      logic [31:0]       addr;   // Byte address, or sector number for an erase
      logic [LINE_W-1:0] data;   // One whole aligned line for a program
   } fsec_cmd_t;

   typedef struct packed {
      logic               rdEn;
      logic               wrEn;
      logic               erEn;       // Erases data and ECC bytes together
      logic [LINE_AW-1:0] line;
      logic [LINE_AW:0]   eraseLines;
      logic [LINE_W-1:0]  wrData;
      logic [ECC_W-1:0]   wrEcc;
   } fsec_arr_t;

   typedef struct packed {
      logic              fixed;
      logic              uncorr;
      logic [LINE_W-1:0] data;
   } fsec_dec_t;

endpackage

// [fsec_array_model.sv]
// Behavioural flash array with its hidden ECC store
`timescale 1ns/100ps
`default_nettype none
module fsec_array_model (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire fsec_pkg::fsec_arr_t arrReq,
   input  wire logic [3:0]          slow,
   output logic [127:0]             arrRdData,
   output logic [7:0]               arrRdEcc,
   output logic                     arrDone
);
   // ECC byte sits above its line; only the array port ever sees it
   logic [135:0] mem [int];
   logic [135:0] cur;
   int           busy;

   always @(posedge clk) begin
      arrDone <= 1'b0;
      cur = mem.exists(int'(arrReq.line)) ? mem[int'(arrReq.line)] : '1;
      if (arrReq.rdEn)
         {arrRdEcc, arrRdData} <= cur;
      else
         {arrRdEcc, arrRdData} <= ~{arrRdEcc, arrRdData}; // Stale bus never repeats the last value
      if (busy > 1)
         busy <= busy - 1;
      if (busy == 1) begin
         busy <= 0;
         arrDone <= 1'b1;
      end
      if (arrReq.wrEn) begin
         mem[int'(arrReq.line)] = cur & {arrReq.wrEcc, arrReq.wrData}; // Programming only clears bits
         busy <= int'(slow) + 1;
      end
      if (arrReq.erEn) begin
         for (int i = 0; i < int'(arrReq.eraseLines); i++)
            mem.delete(int'(arrReq.line) + i);
         busy <= int'(slow) + 1;
      end
      if (reset) begin
         busy <= 0;
         {arrRdEcc, arrRdData} <= '0;
      end
   end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the flash sector ECC controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench;
   logic                   clk, reset, overlayOff, rdReq, rdReady, rdValid, eccFixed, eccUncorr, busy;
   logic                   cmdValid, cmdReady, cmdDone, arrDone;
   logic [31:0]            rdAddr, rdData;
   logic [127:0]           arrRdData;
   logic [7:0]             arrRdEcc, wEcc;
   logic [13:0]            eLine;
   logic [14:0]            eCnt;
   logic [3:0]             slow;
   fsec_pkg::fsec_size_t   sizeSel;
   fsec_pkg::fsec_cmd_t    cmd;
   fsec_pkg::fsec_status_t cmdStatus;
   fsec_pkg::fsec_arr_t    arrReq;
   int                     errors, checked, cycles, nWr;
   logic [127:0]           lineVal [int];

   fsec_controller fsec_controller_inst (.clk(clk), .reset(reset), .clkEn(1'b1), .sizeSel(sizeSel),
      .overlayOff(overlayOff), .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(rdReady), .rdValid(rdValid),
      .rdData(rdData), .eccFixed(eccFixed), .eccUncorr(eccUncorr), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdStatus(cmdStatus), .arrReq(arrReq),
      .arrRdData(arrRdData), .arrRdEcc(arrRdEcc), .arrDone(arrDone));
   fsec_array_model fsec_array_model_inst (.clk(clk), .reset(reset), .arrReq(arrReq), .slow(slow),
      .arrRdData(arrRdData), .arrRdEcc(arrRdEcc), .arrDone(arrDone));

   // ----------------------------------------------------------------------
   // Clock, monitors and helpers
   // ----------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (arrReq.wrEn) begin
         wEcc <= arrReq.wrEcc;
         nWr <= nWr + 1;
      end
      if (arrReq.erEn) begin
         eLine <= arrReq.line;
         eCnt <= arrReq.eraseLines;
      end
      if (cycles == 20000) begin
         errors++;
         report_and_stop();
      end
   end

   always @(negedge clk) if (busy && !cmdDone) `CHK("rdReady", 1'b0, rdReady)

   function automatic logic [7:0] eccOf(logic [127:0] d);
      logic [7:0] e;
      int         p;
      e = 8'h00;
      p = 3;
      for (int i = 0; i < 128; i++) begin
         while ((p & (p - 1)) == 0) p++;
         if (d[i]) e ^= 8'(p);
         p++;
      end
      return e;
   endfunction

   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic fx, input logic un);
      int n;
      n = 0;
      @(negedge clk);
      rdReq = 1'b1;
      rdAddr = a;
      while (rdReady !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      rdReq = 1'b0;
      // The answer pulse stands from the second edge after the take until the third
      repeat (2) @(negedge clk);
      `CHK("rdValid", 1'b1, rdValid)
      `CHK("rdData", exp, rdData)
      `CHK("eccFixed", fx, eccFixed)
      `CHK("eccUncorr", un, eccUncorr)
   endtask

   task automatic cmdOp(input fsec_pkg::fsec_op_t op, input logic [31:0] a, input logic [127:0] d,
                        input fsec_pkg::fsec_status_t exp);
      int n;
      n = 0;
      @(negedge clk);
      cmdValid = 1'b1;
      cmd = '{op, a, d};
      while (cmdReady !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      @(negedge clk);
      cmdValid = 1'b0;
      busy = (op != fsec_pkg::OP_GO) && (exp == fsec_pkg::ST_OK);
      n = 0;
      while (cmdDone !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      busy = 1'b0;
      `CHK("cmdStatus", exp, cmdStatus)
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      int           ln, k, last, base, len, n0;
      logic [127:0] d;
      logic [31:0]  a;
      reset = 1'b1;
      overlayOff = 1'b0;
      rdReq = 1'b0;
      rdAddr = '0;
      cmdValid = 1'b0;
      cmd = '0;
      slow = 4'h0;
      busy = 1'b0;
      sizeSel = fsec_pkg::SZ_256K;
      void'($urandom(32'hae7c67af));
      repeat (2) @(negedge clk);
      reset = 1'b0;
      d = {$urandom, $urandom, $urandom, $urandom};
      fsec_array_model_inst.mem[32'h0000_3E01] = {eccOf(d), d};
      rd(32'h0000_0014, d[63:32], 1'b0, 1'b0);
      rd(32'h7FFF_E01C, d[127:96], 1'b0, 1'b0);
      @(negedge clk);
      overlayOff = 1'b1;
      @(negedge clk);
      overlayOff = 1'b0;
      rd(32'h0000_0014, 32'hFFFF_FFFF, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         ln = (i == 7) ? ln : $urandom_range(32'h0000_3DFF);
         d = {$urandom, $urandom, $urandom, $urandom};
         slow = 4'($urandom_range(15));
         n0 = nWr;
         cmdOp(fsec_pkg::OP_PROG, 32'(ln * 16), d,
               lineVal.exists(ln) ? fsec_pkg::ST_ECC_USED : fsec_pkg::ST_OK);
         if (lineVal.exists(ln))
            `CHK("writes", n0, nWr)
         else begin
            lineVal[ln] = d;
            `CHK("wrEcc", eccOf(d), wEcc)
         end
         k = $urandom_range(3);
         rd(32'(ln * 16 + k * 4), lineVal[ln][32*k +: 32], 1'b0, 1'b0);
      end
      for (int i = 0; i < 6; i++) begin
         k = $urandom_range(135);
         fsec_array_model_inst.mem[ln] = {eccOf(lineVal[ln]), lineVal[ln]} ^ (136'h1 << k);
         rd(32'(ln * 16), lineVal[ln][31:0], 1'b1, 1'b0);
      end
      fsec_array_model_inst.mem[ln] = {eccOf(lineVal[ln]), lineVal[ln]} ^ (136'h1 << 111) ^ (136'h1 << 127);
      d = lineVal[ln] ^ (128'h1 << 111) ^ (128'h1 << 127);
      rd(32'(ln * 16 + 12), d[127:96], 1'b0, 1'b1);
      ln = $urandom_range(32'h0000_3D00);
      while (lineVal.exists(ln)) ln++;
      slow = 4'hF;
      fork
         cmdOp(fsec_pkg::OP_PROG, 32'(ln * 16), d, fsec_pkg::ST_OK);
         begin
            // Data read only: vector fetches stay masked while the program runs
            repeat (3) @(negedge clk);
            rd(32'(ln * 16), d[31:0], 1'b0, 1'b0);
         end
      join
      for (int s = 0; s < 3; s++) begin
         sizeSel = fsec_pkg::fsec_size_t'(s);
         a = 32'h0001_0000 << s;
         cmdOp(fsec_pkg::OP_PROG, a - 32'h0000_2000, d, fsec_pkg::ST_BOOT);
         cmdOp(fsec_pkg::OP_GO, a - 4, d, fsec_pkg::ST_BOOT);
         cmdOp(fsec_pkg::OP_GO, a, d, fsec_pkg::ST_BAD_ADDR);
         cmdOp(fsec_pkg::OP_GO, 32'h0000_0100, d, fsec_pkg::ST_OK);
         last = (s == 0) ? 7 : (s == 1) ? 15 : 17;
         for (int t = 0; t < 19; t++) begin
            base = (t < 8 || s != 2) ? t * 8192 : (t < 10) ? (t - 7) * 65536 : 32'h0003_0000 + (t - 10) * 8192;
            len = (t < 8 || s != 2 || t > 9) ? 8192 : 65536;
            slow = 4'($urandom_range(15));
            cmdOp(fsec_pkg::OP_ERASE, 32'(t), d,
                  t > last ? fsec_pkg::ST_BAD_ADDR : t == last ? fsec_pkg::ST_BOOT : fsec_pkg::ST_OK);
            if (t < last) begin
               `CHK("eraseLine", 14'(base >> 4), eLine)
               `CHK("eraseLines", 15'(len >> 4), eCnt)
            end
         end
      end
      rd(32'(ln * 16), 32'hFFFF_FFFF, 1'b0, 1'b0);
      cmdOp(fsec_pkg::OP_PROG, 32'(ln * 16), d, fsec_pkg::ST_OK);
      report_and_stop();
   end
endmodule
`default_nettype wire
